// file: bcc_core.sv
// byte cpu core: working registers, three address spaces, opcode sequencer
// Operation
// [RULE1] five working registers, pc sixteen bits
// [RULE2] reset clears registers, flags become 02h
// [RULE3] push steps stack pointer automatically
// [RULE4] stack pointer wraps FFh to 00h silently
// [RULE5] only flags visible, at F7h both banks
// [RULE6] rom, ram, register spaces on separate buses
// [RULE7] pc increments across flash block boundaries
// [RULE8] page-spanning non-jump instruction adds one cycle
// [RULE9] register space: two banks of 256 bytes
// [RULE10] bank bit in flags picks register bank
// [RULE11] firmware keeps bank 0 selected normally
// [RULE12] opcode 00 system call, 15 cycles
// [RULE13] opcode 01 add immediate, carry and zero
// [RULE14] opcode 08 pushes accumulator, 4 cycles
// [RULE15] opcode 30 halts, 9 cycles
// [RULE16] opcode 31 xor immediate, zero only
// [RULE17] opcode 38 adds signed immediate to sp
// [RULE18] opcode 39 compares, accumulator kept
// [RULE19] opcode 3E indirect load, pointer post-increment
// [RULE20] opcode 5D reads register space to accumulator
// [RULE21] opcode 60 writes accumulator to register space
// [RULE22] opcode 64 shifts left, top bit to carry
// [RULE23] undefined opcodes run as four-cycle no-ops
// [RULE24] full cycle count before next fetch
`timescale 1ns/1ns
`default_nettype none
module bcc_core (
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	input  wire logic        clk_en,
	output logic [15:0]      rom_addr,
	input  wire logic [7:0]  rom_data,
	output logic [7:0]       ram_addr,
	output logic [7:0]       ram_wdata,
	output logic             ram_we,
	output logic             ram_re,
	input  wire logic [7:0]  ram_rdata,
	output logic [7:0]       reg_addr,
	output logic             reg_bank,
	output logic [7:0]       reg_wdata,
	output logic             reg_we,
	output logic             reg_re,
	input  wire logic [7:0]  reg_rdata,
	output logic             halted,
	output logic             syscall
);
	import bcc_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	bcc_state_e       state, next_state;
	logic [CNT_W-1:0] cnt, next_cnt;
	logic [CNT_W-1:0] total, next_total;
	logic [7:0]       op, next_op;
	logic [7:0]       opnd, next_opnd;
	logic [7:0]       ptr, next_ptr;
	logic [7:0]       acc, next_acc;
	logic [7:0]       idx, next_idx;
	logic [15:0]      pc, next_pc;
	logic [7:0]       sp, next_sp;
	logic [7:0]       flags, next_flags;
	logic [15:0]      next_rom_addr;
	logic [7:0]       next_ram_addr, next_ram_wdata;
	logic             next_ram_we, next_ram_re;
	logic [7:0]       next_reg_addr, next_reg_wdata;
	logic             next_reg_bank, next_reg_we, next_reg_re;
	logic             next_halted, next_syscall;
	logic             run, exec_now;
	logic [7:0]       rd_val;

	bcc_alu_if alu_bus ();

	bcc_alu u_alu (
		.alu (alu_bus)
	);

	assign alu_bus.op  = op_alu(op);
	assign alu_bus.a   = acc;
	assign alu_bus.b   = opnd;
	assign alu_bus.cin = flags[FLAG_C];

	assign run      = (state == BCC_RUN);
	assign exec_now = (cnt == ((op_bytes(op) == BYTES_TWO) ? STEP_EXEC : STEP_OPERAND));
	// flags shadow the register space at their address in either bank
	assign rd_val   = (opnd == FLAGS_ADDR) ? flags : reg_rdata; // see [RULE5]

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	always_comb begin
		next_state     = state;
		next_cnt       = cnt;
		next_total     = total;
		next_op        = op;
		next_opnd      = opnd;
		next_ptr       = ptr;
		next_acc       = acc;
		next_idx       = idx;
		next_pc        = pc;
		next_sp        = sp;
		next_flags     = flags;
		next_rom_addr  = rom_addr;
		next_ram_addr  = ram_addr;
		next_ram_wdata = ram_wdata;
		next_ram_we    = 1'b0;
		next_ram_re    = 1'b0;
		next_reg_addr  = reg_addr;
		next_reg_bank  = reg_bank;
		next_reg_wdata = reg_wdata;
		next_reg_we    = 1'b0;
		next_reg_re    = 1'b0;
		next_halted    = halted;
		next_syscall   = 1'b0;
		case (state)
			BCC_RUN: begin
				next_cnt = cnt + CNT_ONE;
				if (cnt == STEP_OPCODE) begin
					// opcode comes over the dedicated program bus
					next_op       = rom_data; // see [RULE6]
					next_total    = op_cycles(rom_data); // see [RULE23]
					next_pc       = pc + PC_STEP; // see [RULE7]
					next_rom_addr = pc + PC_STEP;
				end else if (cnt == STEP_OPERAND && op_bytes(op) == BYTES_TWO) begin
					next_opnd     = rom_data;
					next_pc       = pc + PC_STEP; // see [RULE7]
					next_rom_addr = pc + PC_STEP;
					// operand sits in the next flash page
					if (pc[PAGE_MSB:0] == PAGE_START) begin
						next_total = total + CNT_ONE; // see [RULE8]
					end
				end
				if (exec_now) begin
					case (op)
						OP_ADD_IMM, OP_ADC_IMM, OP_SUB_IMM, OP_SBB_IMM, OP_XOR_IMM,
						OP_SHIFT_LEFT: begin
							next_acc = alu_bus.res; // see [RULE13]
							next_flags[FLAG_Z] = (alu_bus.res == DATA_RESET);
							if (alu_bus.upd_c) begin
								next_flags[FLAG_C] = alu_bus.cout; // see [RULE16] [RULE22]
							end
						end
						OP_CMP_IMM: begin
							next_flags[FLAG_Z] = (alu_bus.res == DATA_RESET); // see [RULE18]
							next_flags[FLAG_C] = alu_bus.cout;
						end
						OP_PUSH: begin
							next_ram_addr  = sp; // see [RULE14]
							next_ram_wdata = acc;
							next_ram_we    = 1'b1;
							next_sp        = sp + DATA_ONE; // see [RULE3] [RULE4]
						end
						OP_ADD_SP: next_sp = sp + opnd; // see [RULE17]
						OP_IND_POSTINC: begin
							next_ram_addr = opnd; // see [RULE19]
							next_ram_re   = 1'b1;
						end
						OP_REG_READ: begin
							if (opnd != FLAGS_ADDR) begin
								next_reg_addr = opnd; // see [RULE20] [RULE9]
								next_reg_bank = flags[FLAG_BANK]; // see [RULE10]
								next_reg_re   = 1'b1;
							end
						end
						OP_REG_WRITE: begin
							if (opnd == FLAGS_ADDR) begin
								next_flags = acc; // see [RULE5]
							end else begin
								next_reg_addr  = opnd; // see [RULE21] [RULE9]
								next_reg_bank  = flags[FLAG_BANK]; // see [RULE10]
								next_reg_wdata = acc;
								next_reg_we    = 1'b1;
							end
						end
						default: begin
							// system call, halt and undefined opcodes change nothing here
							next_flags = flags; // see [RULE12] [RULE23]
						end
					endcase
				end
				if (cnt == STEP_DATA && op == OP_REG_READ) begin
					next_acc = rd_val; // see [RULE20]
					next_flags[FLAG_Z] = (rd_val == DATA_RESET);
				end
				if (cnt == STEP_DATA && op == OP_IND_POSTINC) begin
					next_ptr      = ram_rdata; // see [RULE19]
					next_ram_addr = ram_rdata;
					next_ram_re   = 1'b1;
				end
				if (cnt == STEP_IND_DATA && op == OP_IND_POSTINC) begin
					next_acc = ram_rdata; // see [RULE19]
					next_flags[FLAG_Z] = (ram_rdata == DATA_RESET);
					next_ram_addr  = opnd;
					next_ram_wdata = ptr + DATA_ONE;
					next_ram_we    = 1'b1;
				end
				// next fetch only once the whole count has run
				if (cnt == total - CNT_ONE) begin
					next_cnt = STEP_OPCODE; // see [RULE24]
					if (op == OP_HALT) begin
						next_state  = BCC_HALT; // see [RULE15]
						next_halted = 1'b1;
					end
					if (op == OP_SYSCALL) begin
						next_syscall = 1'b1; // see [RULE12]
					end
				end
			end
			default: next_halted = 1'b1;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state     <= BCC_RUN;
			cnt       <= STEP_OPCODE;
			total     <= CYC_FOUR;
			op        <= DATA_RESET;
			opnd      <= DATA_RESET;
			ptr       <= DATA_RESET;
			acc       <= DATA_RESET; // see [RULE1] [RULE2]
			idx       <= DATA_RESET;
			pc        <= PC_RESET;
			sp        <= DATA_RESET;
			flags     <= FLAGS_RESET;
			rom_addr  <= PC_RESET;
			ram_addr  <= DATA_RESET;
			ram_wdata <= DATA_RESET;
			ram_we    <= 1'b0;
			ram_re    <= 1'b0;
			reg_addr  <= DATA_RESET;
			reg_bank  <= 1'b0;
			reg_wdata <= DATA_RESET;
			reg_we    <= 1'b0;
			reg_re    <= 1'b0;
			halted    <= 1'b0;
			syscall   <= 1'b0;
		end else if (clk_en) begin
			state     <= next_state;
			cnt       <= next_cnt;
			total     <= next_total;
			op        <= next_op;
			opnd      <= next_opnd;
			ptr       <= next_ptr;
			acc       <= next_acc;
			idx       <= next_idx;
			pc        <= next_pc;
			sp        <= next_sp;
			flags     <= next_flags;
			rom_addr  <= next_rom_addr;
			ram_addr  <= next_ram_addr;
			ram_wdata <= next_ram_wdata;
			ram_we    <= next_ram_we;
			ram_re    <= next_ram_re;
			reg_addr  <= next_reg_addr;
			reg_bank  <= next_reg_bank;
			reg_wdata <= next_reg_wdata;
			reg_we    <= next_reg_we;
			reg_re    <= next_reg_re;
			halted    <= next_halted;
			syscall   <= next_syscall;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn || !clk_en);

	sequence s_push_start;
		run && cnt == STEP_OPCODE && rom_data == OP_PUSH;
	endsequence
	sequence s_syscall_start;
		run && cnt == STEP_OPCODE && rom_data == OP_SYSCALL;
	endsequence

	a_push_cycles: assert property ( // see [RULE14] [RULE24]
		s_push_start |-> ##1 (cnt != STEP_OPCODE)[*3] ##1 (cnt == STEP_OPCODE))
		else $error("push did not take four cycles");
	a_push_steps_sp: assert property ( // see [RULE3]
		run && exec_now && op == OP_PUSH |=> sp == $past(sp) + DATA_ONE && ram_we &&
		ram_wdata == $past(acc) && flags == $past(flags))
		else $error("push did not store and step");
	a_sp_wraps: assert property ( // see [RULE4]
		run && exec_now && op == OP_PUSH && sp == SP_TOP |=> sp == DATA_RESET)
		else $error("stack pointer did not wrap");
	a_flags_read: assert property ( // see [RULE5]
		run && cnt == STEP_DATA && op == OP_REG_READ && opnd == FLAGS_ADDR |=>
		acc == $past(flags))
		else $error("flags not read at their address");
	a_bank_select: assert property ( // see [RULE10]
		reg_re || reg_we |-> reg_bank == $past(flags[FLAG_BANK]))
		else $error("register bank does not follow flag");
	a_page_extra: assert property ( // see [RULE8]
		run && cnt == STEP_OPERAND && op_bytes(op) == BYTES_TWO &&
		pc[PAGE_MSB:0] == PAGE_START |=> total == op_cycles(op) + CNT_ONE)
		else $error("page span cycle missing");
	a_xor_keeps_c: assert property ( // see [RULE16]
		run && exec_now && op == OP_XOR_IMM |=>
		flags[FLAG_C] == $past(flags[FLAG_C]) && flags[FLAG_Z] == (acc == DATA_RESET))
		else $error("xor touched carry");
	a_cmp_keeps_acc: assert property ( // see [RULE18]
		run && exec_now && op == OP_CMP_IMM |=> acc == $past(acc) &&
		flags[FLAG_C] == ($past(acc) < $past(opnd)) &&
		flags[FLAG_Z] == ($past(acc) == $past(opnd)))
		else $error("compare result wrong");
	a_shift_carry: assert property ( // see [RULE22]
		run && exec_now && op == OP_SHIFT_LEFT |=>
		flags[FLAG_C] == $past(acc[7]) && acc == {$past(acc[6:0]), 1'b0})
		else $error("shift left wrong");
	a_syscall_len: assert property ( // see [RULE12]
		s_syscall_start |-> ##15 (syscall && cnt == STEP_OPCODE &&
		flags == $past(flags, 15)))
		else $error("system call length or flags wrong");
	a_halt_holds: assert property ( // see [RULE15]
		halted |=> halted && $stable(pc) && !ram_we && !reg_we)
		else $error("core left halt");
endmodule
`default_nettype wire

// file: bcc_pkg.sv
// constants, opcodes and decode helpers shared by the byte cpu core
`default_nettype none
package bcc_pkg;
	localparam int              DATA_W      = 8;
	localparam int              PC_W        = 16;
	localparam int              CNT_W       = 5;
	localparam logic [7:0]      DATA_RESET  = 8'h00;
	localparam logic [15:0]     PC_RESET    = 16'h0000;
	localparam logic [7:0]      FLAGS_RESET = 8'h02;
	localparam logic [7:0]      FLAGS_ADDR  = 8'hf7;
	localparam logic [7:0]      SP_TOP      = 8'hff;
	localparam int              FLAG_Z      = 1;
	localparam int              FLAG_C      = 2;
	localparam int              FLAG_BANK   = 4;
	localparam int              PAGE_MSB    = 6;
	localparam logic [6:0]      PAGE_START  = 7'h00;
	localparam logic [7:0]      DATA_ONE    = 8'h01;
	localparam logic [15:0]     PC_STEP     = 16'h0001;
	localparam logic [CNT_W-1:0] CNT_ONE    = 5'h01;
	localparam logic [1:0]      BYTES_ONE   = 2'h1;
	localparam logic [1:0]      BYTES_TWO   = 2'h2;

	// ------------------------------------------------------------
	// opcodes
	// ------------------------------------------------------------
	localparam logic [7:0] OP_SYSCALL     = 8'h00;
	localparam logic [7:0] OP_ADD_IMM     = 8'h01;
	localparam logic [7:0] OP_PUSH        = 8'h08;
	localparam logic [7:0] OP_ADC_IMM     = 8'h09;
	localparam logic [7:0] OP_SUB_IMM     = 8'h11;
	localparam logic [7:0] OP_SBB_IMM     = 8'h19;
	localparam logic [7:0] OP_HALT        = 8'h30;
	localparam logic [7:0] OP_XOR_IMM     = 8'h31;
	localparam logic [7:0] OP_ADD_SP      = 8'h38;
	localparam logic [7:0] OP_CMP_IMM     = 8'h39;
	localparam logic [7:0] OP_IND_POSTINC = 8'h3e;
	localparam logic [7:0] OP_REG_READ    = 8'h5d;
	localparam logic [7:0] OP_REG_WRITE   = 8'h60;
	localparam logic [7:0] OP_SHIFT_LEFT  = 8'h64;

	// ------------------------------------------------------------
	// cycle counts and step indices
	// ------------------------------------------------------------
	localparam logic [CNT_W-1:0] CYC_SYSCALL   = 5'h0f;
	localparam logic [CNT_W-1:0] CYC_FOUR      = 5'h04;
	localparam logic [CNT_W-1:0] CYC_FIVE      = 5'h05;
	localparam logic [CNT_W-1:0] CYC_REG_READ  = 5'h06;
	localparam logic [CNT_W-1:0] CYC_HALT      = 5'h09;
	localparam logic [CNT_W-1:0] CYC_IND       = 5'h0a;
	localparam logic [CNT_W-1:0] STEP_OPCODE   = 5'h00;
	localparam logic [CNT_W-1:0] STEP_OPERAND  = 5'h01;
	localparam logic [CNT_W-1:0] STEP_EXEC     = 5'h02;
	localparam logic [CNT_W-1:0] STEP_DATA     = 5'h03;
	localparam logic [CNT_W-1:0] STEP_IND_DATA = 5'h04;

	typedef enum logic [2:0] {
		ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBB, ALU_CMP, ALU_XOR, ALU_SHL, ALU_PASS
	} bcc_alu_op_e;

	typedef enum logic {BCC_RUN, BCC_HALT} bcc_state_e;

	function automatic logic [1:0] op_bytes(input logic [7:0] opc);
		case (opc)
			OP_ADD_IMM, OP_ADC_IMM, OP_SUB_IMM, OP_SBB_IMM, OP_XOR_IMM, OP_ADD_SP,
			OP_CMP_IMM, OP_IND_POSTINC, OP_REG_READ, OP_REG_WRITE: op_bytes = BYTES_TWO;
			default: op_bytes = BYTES_ONE;
		endcase
	endfunction

	function automatic logic [CNT_W-1:0] op_cycles(input logic [7:0] opc);
		case (opc)
			OP_SYSCALL:                 op_cycles = CYC_SYSCALL;
			OP_HALT:                    op_cycles = CYC_HALT;
			OP_ADD_SP, OP_CMP_IMM:      op_cycles = CYC_FIVE;
			OP_REG_WRITE:               op_cycles = CYC_FIVE;
			OP_REG_READ:                op_cycles = CYC_REG_READ;
			OP_IND_POSTINC:             op_cycles = CYC_IND;
			default:                    op_cycles = CYC_FOUR;
		endcase
	endfunction

	function automatic bcc_alu_op_e op_alu(input logic [7:0] opc);
		case (opc)
			OP_ADD_IMM:    op_alu = ALU_ADD;
			OP_ADC_IMM:    op_alu = ALU_ADC;
			OP_SUB_IMM:    op_alu = ALU_SUB;
			OP_SBB_IMM:    op_alu = ALU_SBB;
			OP_CMP_IMM:    op_alu = ALU_CMP;
			OP_XOR_IMM:    op_alu = ALU_XOR;
			OP_SHIFT_LEFT: op_alu = ALU_SHL;
			default:       op_alu = ALU_PASS;
		endcase
	endfunction
endpackage
`default_nettype wire

// file: bcc_alu_if.sv
// operand and result bundle between the core sequencer and its alu
`timescale 1ns/1ns
`default_nettype none
interface bcc_alu_if;
	import bcc_pkg::*;
	bcc_alu_op_e op;
	logic [7:0]  a;
	logic [7:0]  b;
	logic        cin;
	logic [7:0]  res;
	logic        cout;
	logic        upd_c;
	modport core (output op, output a, output b, output cin,
		input res, input cout, input upd_c);
	modport alu (input op, input a, input b, input cin,
		output res, output cout, output upd_c);
endinterface
`default_nettype wire

// file: bcc_alu.sv
// eight bit arithmetic and logic unit of the byte cpu core
`timescale 1ns/1ns
`default_nettype none
module bcc_alu (
	bcc_alu_if.alu alu
);
	import bcc_pkg::*;
	logic [8:0] wide;

	always_comb begin
		wide = {1'b0, alu.a};
		alu.upd_c = 1'b1;
		case (alu.op)
			ALU_ADD: wide = {1'b0, alu.a} + {1'b0, alu.b}; // see [RULE13]
			ALU_ADC: wide = {1'b0, alu.a} + {1'b0, alu.b} + {8'h00, alu.cin};
			ALU_SUB, ALU_CMP: wide = {1'b0, alu.a} - {1'b0, alu.b};
			ALU_SBB: wide = {1'b0, alu.a} - {1'b0, alu.b} - {8'h00, alu.cin};
			ALU_XOR: begin
				wide = {1'b0, alu.a ^ alu.b}; // see [RULE16]
				alu.upd_c = 1'b0;
			end
			ALU_SHL: wide = {alu.a, 1'b0}; // see [RULE22]
			default: alu.upd_c = 1'b0;
		endcase
		alu.res = wide[7:0];
		alu.cout = wide[8];
	end
endmodule
`default_nettype wire

// file: bcc_mem_model.sv
// program rom, data ram and two-bank register space facing the core
`timescale 1ns/1ns
`default_nettype none
module bcc_mem_model (
	input  wire logic        sys_clk,
	input  wire logic [15:0] rom_addr,
	output logic [7:0]       rom_data,
	input  wire logic [7:0]  ram_addr,
	input  wire logic [7:0]  ram_wdata,
	input  wire logic        ram_we,
	input  wire logic        ram_re,
	output logic [7:0]       ram_rdata,
	input  wire logic [7:0]  reg_addr,
	input  wire logic        reg_bank,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_we,
	input  wire logic        reg_re,
	output logic [7:0]       reg_rdata
);
	logic [7:0] rom [0:255];
	logic [7:0] ram [0:255];
	logic [7:0] regs [0:511];
	logic [7:0] ram_last = 8'h00;
	logic [7:0] reg_last = 8'h00;
	// zero-latency program store on its own bus
	assign rom_data = rom[rom_addr[7:0]];
	// an idle read bus shows the inverse of the last byte, never a stale copy
	assign ram_rdata = ram_re ? ram[ram_addr] : ~ram_last;
	assign reg_rdata = reg_re ? regs[{reg_bank, reg_addr}] : ~reg_last;
	always @(posedge sys_clk) begin
		if (ram_we) ram[ram_addr] <= ram_wdata;
		if (ram_re) ram_last <= ram[ram_addr];
		if (reg_we) regs[{reg_bank, reg_addr}] <= reg_wdata;
		if (reg_re) reg_last <= regs[{reg_bank, reg_addr}];
	end
endmodule
`default_nettype wire

// file: byte_cpu_core_regs_decode_bench.sv
// self-checking bench running small programs on the byte cpu core
`timescale 1ns/1ns
`default_nettype none
module byte_cpu_core_regs_decode_bench;
	import bcc_pkg::*;
	logic        sys_clk = 1'b0;
	logic        rstn = 1'b0;
	logic        clk_en = 1'b1;
	logic [15:0] rom_addr;
	logic [7:0]  rom_data, ram_addr, ram_wdata, ram_rdata;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata;
	logic        ram_we, ram_re, reg_bank, reg_we, reg_re, halted, syscall;
	int          errors = 0;
	int          n_checks = 0;
	int          n_cyc = 0;
	int          n_sys = 0;
	logic [15:0] base;
	always #20 sys_clk = ~sys_clk;
	bcc_core uut (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en), .rom_addr(rom_addr),
		.rom_data(rom_data), .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_we(ram_we),
		.ram_re(ram_re), .ram_rdata(ram_rdata), .reg_addr(reg_addr), .reg_bank(reg_bank),
		.reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
		.halted(halted), .syscall(syscall));
	bcc_mem_model mem (.sys_clk(sys_clk), .rom_addr(rom_addr), .rom_data(rom_data),
		.ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_we(ram_we), .ram_re(ram_re),
		.ram_rdata(ram_rdata), .reg_addr(reg_addr), .reg_bank(reg_bank),
		.reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata));
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// counted off the edge so the one-cycle syscall pulse is settled
	always @(negedge sys_clk) begin
		n_cyc++;
		if (syscall === 1'b1) n_sys++;
		if (n_cyc == 5000) begin
			errors++;
			finish_test();
		end
	end
	task automatic prog(input logic [7:0] p [$]);
		for (int i = 0; i < 256; i++) mem.rom[i] = (i < p.size()) ? p[i] : OP_HALT;
	endtask
	// reset, then count edges until halted; clk_en drops for 3 cycles at pause
	task automatic run(input int pause, output logic [15:0] cyc);
		int k;
		@(posedge sys_clk);
		rstn <= 1'b0;
		repeat (4) @(posedge sys_clk);
		@(negedge sys_clk);
		check("reset rom_addr", rom_addr, PC_RESET);
		check("reset strobes", {10'h000, ram_we, ram_re, reg_we, reg_re, halted, syscall},
			16'h0000);
		@(posedge sys_clk);
		rstn <= 1'b1;
		n_sys = 0;
		for (k = 0; k < 2000; k++) begin
			@(posedge sys_clk);
			clk_en <= !(k >= pause && k < pause + 3);
			// halted is looked at once it has settled after the edge
			@(negedge sys_clk);
			if (halted === 1'b1) break;
		end
		cyc = 16'(k);
		repeat (3) @(negedge sys_clk);
		check("halted stays", {15'h0000, halted}, 16'h0001);
	endtask
	task automatic expect_ram(input logic [7:0] a, input logic [7:0] e [$]);
		foreach (e[i]) check("ram byte", {8'h00, mem.ram[8'(a + i)]}, {8'h00, e[i]});
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_base();
		prog('{8'h30});
		run(9999, base);
	endtask
	task automatic t_flags_stack();
		logic [15:0] c;
		mem.regs[16'h0010] = 8'hff;
		mem.regs[16'h00f7] = 8'hee;
		prog('{8'h5d, 8'hf7, 8'h08, 8'h08, 8'h60, 8'h10, 8'h30});
		run(5, c);
		check("cycles", c - base, 16'h0016);
		expect_ram(8'h00, '{8'h02, 8'h02});
		check("reg write", {8'h00, mem.regs[16'h0010]}, 16'h0002);
		check("f7 hidden", {8'h00, mem.regs[16'h00f7]}, 16'h00ee);
	endtask
	task automatic t_alu();
		logic [15:0] c;
		prog('{8'h01, 8'hff, 8'h01, 8'h02, 8'h5d, 8'hf7, 8'h08, 8'h31, 8'h04, 8'h5d, 8'hf7,
			8'h08, 8'h64, 8'h08, 8'h39, 8'h0c, 8'h08, 8'h5d, 8'hf7, 8'h08, 8'h01, 8'h7e,
			8'h64, 8'h5d, 8'hf7, 8'h08, 8'h39, 8'h07, 8'h5d, 8'hf7, 8'h08});
		run(9999, c);
		check("cycles", c - base, 16'h005c);
		expect_ram(8'h00, '{8'h04, 8'h06, 8'h0c});
		expect_ram(8'h03, '{8'h0c, 8'h02, 8'h06, 8'h04});
	endtask
	task automatic t_sp_ind();
		logic [15:0] c;
		mem.ram[8'h40] = 8'h50;
		mem.ram[8'h50] = 8'h77;
		prog('{8'h38, 8'hfe, 8'h01, 8'haa, 8'h08, 8'h08, 8'h08, 8'h3e, 8'h40, 8'h08, 8'h11,
			8'h78, 8'h09, 8'h00, 8'h08, 8'h5d, 8'hf7, 8'h08, 8'h19, 8'h00, 8'h08});
		run(9999, c);
		check("cycles", c - base, 16'h0041);
		expect_ram(8'hfe, '{8'haa, 8'haa, 8'haa});
		expect_ram(8'h01, '{8'h77, 8'h00, 8'h06, 8'h05});
		check("pointer", {8'h00, mem.ram[8'h40]}, 16'h0051);
	endtask
	task automatic t_banks();
		logic [15:0] c;
		mem.regs[16'h0020] = 8'h5a;
		mem.regs[16'h0121] = 8'h3c;
		mem.regs[16'h00f7] = 8'hee;
		mem.regs[16'h01f7] = 8'hee;
		// bank 1 only for the two accesses that need it, then back to bank 0
		prog('{8'h01, 8'h10, 8'h60, 8'hf7, 8'h60, 8'h20, 8'h5d, 8'h21, 8'h08, 8'h40, 8'h31,
			8'h3c, 8'h60, 8'hf7, 8'h60, 8'h20, 8'h5d, 8'hf7, 8'h08});
		run(9999, c);
		check("cycles", c - base, 16'h0034);
		check("bank1 write", {8'h00, mem.regs[16'h0120]}, 16'h0010);
		check("bank0 write", {8'h00, mem.regs[16'h0020]}, 16'h0000);
		expect_ram(8'h00, '{8'h3c, 8'h00});
		check("f7 bank1", {8'h00, mem.regs[16'h01f7]}, 16'h00ee);
		check("f7 bank0", {8'h00, mem.regs[16'h00f7]}, 16'h00ee);
	endtask
	task automatic t_page_syscall();
		logic [7:0]  p [$];
		logic [15:0] c;
		for (int i = 0; i < 125; i++) p.push_back(8'h40);
		p = {p, 8'h01, 8'hff, 8'h01, 8'h01, 8'h00, 8'h5d, 8'hf7, 8'h08};
		prog(p);
		run(9999, c);
		check("cycles", c - base, 16'h0216);
		check("syscall pulses", 16'(n_sys), 16'h0001);
		expect_ram(8'h00, '{8'h06});
	endtask
	initial begin
		t_base();
		t_flags_stack();
		t_alu();
		t_sp_ind();
		t_banks();
		t_page_syscall();
		finish_test();
	end
endmodule
`default_nettype wire
